// >>> common/iepx_pkg.sv
package iepx_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_PRIO_BASE  = 8'hb8;
    localparam logic [7:0] IDX_EN_EXT_ONE = 8'he6;
    localparam logic [7:0] IDX_EN_EXT_TWO = 8'he7;
    localparam logic [7:0] IDX_EXT_CFG    = 8'hf4;
    localparam logic [7:0] IDX_PRIO_EXT1  = 8'hf6;
    localparam logic [7:0] IDX_PRIO_EXT2  = 8'hf7;
    localparam logic [7:0] IDX_GLOBAL_EN  = 8'h10;
    localparam logic [7:0] IDX_STATUS     = 8'h11;
    localparam int         ADDR_W         = 10;

    localparam logic [7:0] RST_PRIO_BASE  = 8'h80;
    localparam logic [7:0] RST_EN_EXT_ONE = 8'h00;
    localparam logic [7:0] RST_EN_EXT_TWO = 8'h00;
    localparam logic [7:0] RST_EXT_CFG    = 8'h01;
    localparam logic [7:0] RST_PRIO_EXT1  = 8'h00;
    localparam logic [7:0] RST_PRIO_EXT2  = 8'h00;

    localparam logic [7:0] PRIO_BASE_FIXED = 8'h80;
    localparam logic [7:0] EXT_TWO_MASK    = 8'h03;

    localparam int POS_EXT1_POL = 7;
    localparam int POS_EXT1_SEL = 4;
    localparam int POS_EXT0_POL = 3;
    localparam int POS_EXT0_SEL = 0;

    localparam int NUM_SRC = 17;
    localparam logic [4:0] SRC_NONE = 5'h1f;
endpackage

// >>> core/iepx_irq_ctrl.sv
// Overview of operation
// RL1 - base priority register top bit always reads one; writes to it ignored
// RL2 - base priority bits 6..0 set spi, timer2, uart0, timer1, ext1, timer0, ext0 levels
// RL3 - extended enable one bit 7 gates timer three low or high overflow requests
// RL4 - extended enable one bit 6 gates comparator one rise or fall requests
// RL5 - extended enable one bit 5 gates comparator zero rise or fall requests
// RL6 - extended enable one bit 4 gates all counter array requests
// RL7 - extended enable one bit 3 gates conversion complete requests
// RL8 - extended enable one bit 2 gates window compare requests
// RL9 - extended enable one bit 1 gates all usb controller requests
// RL10 - extended enable one bit 0 gates all smbus controller requests
// RL11 - extended priority one mirrors enable one layout, one selects high level
// RL12 - extended enable two and priority two bits 7..2 read zero, writes ignored
// RL13 - extended enable two bit 1 gates uart one requests
// RL14 - extended enable two bit 0 gates bus supply sense requests
// RL15 - extended priority two bits 1,0 set uart one and bus supply levels
// RL16 - config bit 7 makes external input one active low or high
// RL17 - config bits 6..4 choose port zero pin for external input one
// RL18 - config bit 3 makes external input zero active low or high
// RL19 - config bits 2..0 choose port zero pin for external input zero
// RL20 - external inputs tap port pins directly, never disturbing crossbar routing
// RL21 - global enable clear blocks every source; set lets each mask decide
// RL22 - high level requests first; fixed source order breaks ties within a level
`timescale 1ns/100ps
module iepx_irq_ctrl (
    input  wire logic        i_ref_clk,        // system clock, 10 MHz
    input  wire logic        i_rst,            // synchronous reset, active high
    input  wire logic [31:0] i_wb_adr,         // wishbone byte address
    input  wire logic [31:0] i_wb_dat,         // wishbone write data
    input  wire logic [3:0]  i_wb_sel,         // wishbone byte selects
    input  wire logic        i_wb_we,          // wishbone write enable
    input  wire logic        i_wb_cyc,         // wishbone cycle
    input  wire logic        i_wb_stb,         // wishbone strobe
    output logic      [31:0] o_wb_dat,         // wishbone read data
    output logic             o_wb_ack,         // wishbone acknowledge
    input  wire logic [7:0]  i_port_zero,      // port zero pin levels, asynchronous
    input  wire logic [6:0]  i_base_req,       // base requests, bit 0 ext0 .. bit 6 spi
    input  wire logic [6:0]  i_base_en,        // base enables from the base enable register
    input  wire logic        i_timer_three_low_ovf,  // timer three low byte overflow
    input  wire logic        i_timer_three_high_ovf, // timer three high byte overflow
    input  wire logic        i_cmp_one_rise_flag,    // comparator one rising edge
    input  wire logic        i_cmp_one_fall_flag,    // comparator one falling edge
    input  wire logic        i_cmp_zero_rise_flag,   // comparator zero rising edge
    input  wire logic        i_cmp_zero_fall_flag,   // comparator zero falling edge
    input  wire logic        i_counter_array_req,    // counter array request
    input  wire logic        i_conv_done_flag,       // converter conversion complete
    input  wire logic        i_window_cmp_flag,      // converter window compare
    input  wire logic        i_usb_ctrl_req,         // usb controller request
    input  wire logic        i_smbus_ctrl_req,       // smbus controller request
    input  wire logic        i_uart_one_req,         // uart one request
    input  wire logic        i_bus_supply_req,       // bus supply level sense request
    output logic             o_ext_irq_zero,   // external input zero, active high
    output logic             o_ext_irq_one,    // external input one, active high
    output logic             o_irq_valid,      // an enabled request is pending
    output logic             o_irq_high,       // chosen request is high level
    output logic      [4:0]  o_irq_src         // chosen source in vector order
);

    logic [7:0] prio_base_q;
    logic [7:0] en_ext_one_q;
    logic [7:0] en_ext_two_q;
    logic [7:0] ext_cfg_q;
    logic [7:0] prio_ext1_q;
    logic [7:0] prio_ext2_q;
    logic       global_irq_enable_q;
    logic       ack_q;
    logic [31:0] rdat_q;
    logic [7:0] pin_s1_q;
    logic [7:0] pin_s2_q;
    logic [7:0] pin_s3_q;
    logic [7:0] pin_q;
    logic       ext_zero_q;
    logic       ext_one_q;
    logic       valid_q;
    logic       high_q;
    logic [4:0] src_q;

    // bus decode
    wire        bus_req  = i_wb_cyc && i_wb_stb && !ack_q;
    wire        bus_wr   = bus_req && i_wb_we && i_wb_sel[0];
    wire [7:0]  wdat     = i_wb_dat[7:0];
    wire        adr_ok   = (i_wb_adr[1:0] == 2'h0) && (i_wb_adr[31:iepx_pkg::ADDR_W] == '0);
    wire [7:0]  adr_idx  = i_wb_adr[9:2];
    wire        hit_pb   = adr_ok && adr_idx == iepx_pkg::IDX_PRIO_BASE;
    wire        hit_e1   = adr_ok && adr_idx == iepx_pkg::IDX_EN_EXT_ONE;
    wire        hit_e2   = adr_ok && adr_idx == iepx_pkg::IDX_EN_EXT_TWO;
    wire        hit_cf   = adr_ok && adr_idx == iepx_pkg::IDX_EXT_CFG;
    wire        hit_p1   = adr_ok && adr_idx == iepx_pkg::IDX_PRIO_EXT1;
    wire        hit_p2   = adr_ok && adr_idx == iepx_pkg::IDX_PRIO_EXT2;
    wire        hit_ge   = adr_ok && adr_idx == iepx_pkg::IDX_GLOBAL_EN;
    wire        hit_st   = adr_ok && adr_idx == iepx_pkg::IDX_STATUS;

    wire [7:0]  status_rd = {valid_q, high_q, 1'b0, src_q};
    wire [7:0]  rd_byte =
        hit_pb ? prio_base_q :
        hit_e1 ? en_ext_one_q :
        hit_e2 ? en_ext_two_q :
        hit_cf ? ext_cfg_q :
        hit_p1 ? prio_ext1_q :
        hit_p2 ? prio_ext2_q :
        hit_ge ? {7'h00, global_irq_enable_q} :
        hit_st ? status_rd : 8'h00;

    // next register values
    wire [7:0] prio_base_d = hit_pb && bus_wr ?
        (wdat | iepx_pkg::PRIO_BASE_FIXED) : prio_base_q;                    // see RL1
    wire [7:0] en_ext_two_d = hit_e2 && bus_wr ?
        (wdat & iepx_pkg::EXT_TWO_MASK) : en_ext_two_q;                      // see RL12
    wire [7:0] prio_ext2_d = hit_p2 && bus_wr ?
        (wdat & iepx_pkg::EXT_TWO_MASK) : prio_ext2_q;                       // see RL12

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            prio_base_q         <= iepx_pkg::RST_PRIO_BASE;
            en_ext_one_q        <= iepx_pkg::RST_EN_EXT_ONE;
            en_ext_two_q        <= iepx_pkg::RST_EN_EXT_TWO;
            ext_cfg_q           <= iepx_pkg::RST_EXT_CFG;
            prio_ext1_q         <= iepx_pkg::RST_PRIO_EXT1;
            prio_ext2_q         <= iepx_pkg::RST_PRIO_EXT2;
            global_irq_enable_q <= 1'b0;
        end else begin
            prio_base_q  <= prio_base_d;
            en_ext_two_q <= en_ext_two_d;
            prio_ext2_q  <= prio_ext2_d;
            if (hit_e1 && bus_wr) begin
                en_ext_one_q <= wdat;
            end
            if (hit_cf && bus_wr) begin
                ext_cfg_q <= wdat;
            end
            if (hit_p1 && bus_wr) begin
                prio_ext1_q <= wdat;                                         // see RL11
            end
            if (hit_ge && bus_wr) begin
                global_irq_enable_q <= wdat[0];
            end
        end
    end

    // every access, mapped or not, is acknowledged one cycle later
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= bus_req;
            rdat_q <= {24'h00_0000, rd_byte};
        end
    end

    // port pins are only observed, never driven
    always_ff @(posedge i_ref_clk) begin                                    // see RL20
        if (i_rst) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            pin_s3_q <= 8'h00;
            pin_q    <= 8'h00;
        end else begin
            pin_s1_q <= i_port_zero;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
        end
    end

    wire [2:0] sel_one  = ext_cfg_q[iepx_pkg::POS_EXT1_SEL +: 3];
    wire [2:0] sel_zero = ext_cfg_q[iepx_pkg::POS_EXT0_SEL +: 3];
    // active low polarity inverts the selected pin
    wire ext_one_d  = pin_q[sel_one] ~^ ext_cfg_q[iepx_pkg::POS_EXT1_POL];    // see RL16 RL17
    wire ext_zero_d = pin_q[sel_zero] ~^ ext_cfg_q[iepx_pkg::POS_EXT0_POL];   // see RL18 RL19

    // masked requests in vector order, index = priority order
    wire [iepx_pkg::NUM_SRC-1:0] req_vec = {
        i_uart_one_req,
        i_bus_supply_req,
        i_timer_three_low_ovf | i_timer_three_high_ovf,
        i_cmp_one_rise_flag | i_cmp_one_fall_flag,
        i_cmp_zero_rise_flag | i_cmp_zero_fall_flag,
        i_counter_array_req,
        i_conv_done_flag,
        i_window_cmp_flag,
        i_usb_ctrl_req,
        i_smbus_ctrl_req,
        i_base_req[6:0]
    };
    wire [6:0] base_order_en = i_base_en;
    wire [iepx_pkg::NUM_SRC-1:0] en_vec = {
        en_ext_two_q[1:0],                                                   // see RL13 RL14
        en_ext_one_q[7:0],                                    // see RL3 RL4 RL5 RL6 RL7 RL8 RL9 RL10
        base_order_en
    };
    wire [iepx_pkg::NUM_SRC-1:0] prio_vec = {
        prio_ext2_q[1:0],                                                    // see RL15
        prio_ext1_q[7:0],                                                    // see RL11
        prio_base_q[6:0]                                                     // see RL2
    };
    wire [iepx_pkg::NUM_SRC-1:0] live    = req_vec & en_vec &
        {iepx_pkg::NUM_SRC{global_irq_enable_q}};                             // see RL21
    wire [iepx_pkg::NUM_SRC-1:0] live_hi = live & prio_vec;

    function automatic logic [4:0] first_set(input logic [iepx_pkg::NUM_SRC-1:0] v);
        logic [4:0] r;
        r = iepx_pkg::SRC_NONE;
        for (int k = iepx_pkg::NUM_SRC - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = 5'(k);
            end
        end
        return r;
    endfunction

    wire       any_hi  = |live_hi;
    wire [4:0] pick    = any_hi ? first_set(live_hi) : first_set(live);     // see RL22

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ext_zero_q <= 1'b0;
            ext_one_q  <= 1'b0;
            valid_q    <= 1'b0;
            high_q     <= 1'b0;
            src_q      <= iepx_pkg::SRC_NONE;
        end else begin
            ext_zero_q <= ext_zero_d;
            ext_one_q  <= ext_one_d;
            valid_q    <= |live;
            high_q     <= any_hi;
            src_q      <= pick;
        end
    end

    assign o_wb_ack       = ack_q;
    assign o_wb_dat       = rdat_q;
    assign o_ext_irq_zero = ext_zero_q;
    assign o_ext_irq_one  = ext_one_q;
    assign o_irq_valid    = valid_q;
    assign o_irq_high     = high_q;
    assign o_irq_src      = src_q;

    chk_base_top_one: assert property (@(posedge i_ref_clk) disable iff (i_rst)  // see RL1
        prio_base_q[7]) else $error("base priority top bit not one");

    chk_ext_two_upper: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL12
        en_ext_two_q[7:2] == 6'h00 && prio_ext2_q[7:2] == 6'h00)
        else $error("upper bits of second extended registers not zero");

    chk_global_block: assert property (@(posedge i_ref_clk) disable iff (i_rst)  // see RL21
        !global_irq_enable_q |=> !valid_q) else $error("request passed with global off");

    chk_mask_block: assert property (@(posedge i_ref_clk) disable iff (i_rst)    // see RL3
        (en_ext_one_q == 8'h00 && en_ext_two_q == 8'h00 && i_base_en == 7'h00)
        |=> !valid_q) else $error("masked request passed");

    chk_high_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)   // see RL22
        (|live_hi) |=> (high_q && prio_vec[src_q] == $past(prio_vec[pick])))
        else $error("high level request not chosen first");

    chk_order_tie: assert property (@(posedge i_ref_clk) disable iff (i_rst)    // see RL22
        (live[0] && (prio_vec[0] || !(|live_hi))) |=> src_q == 5'h00)
        else $error("source order not kept");

    // the output of a settled cycle reflects the pin and the config of that cycle
    chk_ext_zero_pol: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL18
        !$past(i_rst) && $stable(ext_cfg_q) && $stable(pin_q) |-> o_ext_irq_zero ==
        (pin_q[ext_cfg_q[2:0]] ~^ ext_cfg_q[3])) else $error("ext zero level wrong");

    chk_ext_one_pol: assert property (@(posedge i_ref_clk) disable iff (i_rst)  // see RL16
        !$past(i_rst) && $stable(ext_cfg_q) && $stable(pin_q) |-> o_ext_irq_one ==
        (pin_q[ext_cfg_q[6:4]] ~^ ext_cfg_q[7])) else $error("ext one level wrong");

    chk_ack_one_cycle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        bus_req |=> o_wb_ack ##1 !o_wb_ack) else $error("ack not one cycle");

    // a cleared mask bit keeps its source index from being chosen
    chk_timer_three_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL3
        !en_ext_one_q[7] |=> src_q != 5'h0e)
        else $error("timer three passed while masked");

    chk_cmp_one_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL4
        !en_ext_one_q[6] |=> src_q != 5'h0d)
        else $error("comparator one passed while masked");

    chk_cmp_zero_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL5
        !en_ext_one_q[5] |=> src_q != 5'h0c)
        else $error("comparator zero passed while masked");

    chk_counter_array_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL6
        !en_ext_one_q[4] |=> src_q != 5'h0b)
        else $error("counter array passed while masked");

    chk_conv_done_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL7
        !en_ext_one_q[3] |=> src_q != 5'h0a)
        else $error("conversion complete passed while masked");

    chk_window_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL8
        !en_ext_one_q[2] |=> src_q != 5'h09)
        else $error("window compare passed while masked");

    chk_usb_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL9
        !en_ext_one_q[1] |=> src_q != 5'h08)
        else $error("usb passed while masked");

    chk_smbus_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL10
        !en_ext_one_q[0] |=> src_q != 5'h07)
        else $error("smbus passed while masked");

    chk_uart_one_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL13
        !en_ext_two_q[1] |=> src_q != 5'h10)
        else $error("uart one passed while masked");

    chk_supply_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL14
        !en_ext_two_q[0] |=> src_q != 5'h0f)
        else $error("bus supply passed while masked");

    chk_base_high_level: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL2
        (|(live & {10'h000, prio_base_q[6:0]})) |=> high_q)
        else $error("base high level request not flagged");

    chk_ext_one_level: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL11
        (|(live & {2'h0, prio_ext1_q, 7'h00})) |=> high_q)
        else $error("first extended high level request not flagged");

    chk_ext_two_level: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL15
        (|(live & {prio_ext2_q[1:0], 15'h0000})) |=> high_q)
        else $error("second extended high level request not flagged");

    chk_low_only: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL22
        (|live) && !(|live_hi) |=> valid_q && !high_q)
        else $error("low level request shown as high");

    chk_valid_src_pair: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL22
        valid_q == (src_q != iepx_pkg::SRC_NONE))
        else $error("valid and source disagree");

    // the filtered pin follows only once the last two stages agree
    chk_pin_filter: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL20
        pin_s2_q == pin_s3_q |=> pin_q == $past(pin_s2_q))
        else $error("pin filter did not follow agreed stages");

    chk_pin_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL20
        pin_s2_q[0] != pin_s3_q[0] |=> $stable(pin_q[0]))
        else $error("pin filter moved on disagreeing stages");

    chk_read_upper_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_wb_dat[31:8] == 24'h00_0000)
        else $error("read data upper bytes not zero");

    chk_ack_after_req: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_wb_ack |-> $past(bus_req))
        else $error("ack without a request");

    chk_cfg_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL17 RL19
        hit_cf && bus_wr |=> ext_cfg_q == $past(wdat))
        else $error("config write not stored");

    chk_global_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL21
        hit_ge && bus_wr |=> {7'h00, global_irq_enable_q} == ($past(wdat) & 8'h01))
        else $error("global enable write not stored");

    chk_prio_one_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL11
        hit_p1 && bus_wr |=> prio_ext1_q == $past(wdat))
        else $error("first extended priority write not stored");

    chk_en_one_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL3
        hit_e1 && bus_wr |=> en_ext_one_q == $past(wdat))
        else $error("first extended enable write not stored");

    chk_en_two_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL13
        hit_e2 && bus_wr |=> en_ext_two_q == ($past(wdat) & iepx_pkg::EXT_TWO_MASK))
        else $error("second extended enable write not stored");

    chk_prio_two_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL15
        hit_p2 && bus_wr |=> prio_ext2_q == ($past(wdat) & iepx_pkg::EXT_TWO_MASK))
        else $error("second extended priority write not stored");

    chk_base_prio_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // see RL2
        hit_pb && bus_wr |=> prio_base_q == ($past(wdat) | iepx_pkg::PRIO_BASE_FIXED))
        else $error("base priority write not stored");

endmodule

// >>> testbench/iepx_periph_model.sv
`timescale 1ns/100ps
// stands for the peripherals: every flag is a level held until the bench drops it
module iepx_periph_model (
    input  wire logic        i_alt,  // raise the second flag of two-flag sources
    input  wire logic [16:0] i_req,  // wanted requests in vector order
    output logic      [6:0]  o_base, // base requests
    output logic             o_t3l,  // timer three low overflow
    output logic             o_t3h,  // timer three high overflow
    output logic             o_c1r,  // comparator one rise
    output logic             o_c1f,  // comparator one fall
    output logic             o_c0r,  // comparator zero rise
    output logic             o_c0f,  // comparator zero fall
    output logic             o_smb,  // smbus
    output logic             o_usb,  // usb
    output logic             o_win,  // window compare
    output logic             o_conv, // conversion done
    output logic             o_pca,  // counter array
    output logic             o_vb,   // bus supply sense
    output logic             o_u1    // uart one
);
    assign o_base = i_req[6:0];
    assign o_smb  = i_req[7];
    assign o_usb  = i_req[8];
    assign o_win  = i_req[9];
    assign o_conv = i_req[10];
    assign o_pca  = i_req[11];
    assign o_c0r  = i_req[12] & ~i_alt;
    assign o_c0f  = i_req[12] & i_alt;
    assign o_c1r  = i_req[13] & ~i_alt;
    assign o_c1f  = i_req[13] & i_alt;
    assign o_t3l  = i_req[14] & ~i_alt;
    assign o_t3h  = i_req[14] & i_alt;
    assign o_vb   = i_req[15];
    assign o_u1   = i_req[16];
endmodule

// >>> testbench/test_irq_enable_priority_extint_cfg.sv
`timescale 1ns/100ps
module test_irq_enable_priority_extint_cfg;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, alt = 0;
    logic [31:0] adr = '0, wdat = '0, rdat;
    logic [7:0]  port = '0, rd;
    logic [6:0]  ben = '0, breq;
    logic [16:0] req = '0;
    logic        ack, ez, eo, vld, hi, t3l, t3h, c1r, c1f, c0r, c0f, pca, conv, win, usb, smb, u1, vb;
    logic [4:0]  src;
    int          num_errors = 0, check_count = 0, cycles = 0;

    iepx_periph_model per (.i_alt(alt), .i_req(req), .o_base(breq), .o_t3l(t3l), .o_t3h(t3h),
        .o_c1r(c1r), .o_c1f(c1f), .o_c0r(c0r), .o_c0f(c0f), .o_smb(smb), .o_usb(usb),
        .o_win(win), .o_conv(conv), .o_pca(pca), .o_vb(vb), .o_u1(u1));
    iepx_irq_ctrl dut (.i_ref_clk(clk), .i_rst(rst), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(4'hf), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_port_zero(port), .i_base_req(breq), .i_base_en(ben),
        .i_timer_three_low_ovf(t3l), .i_timer_three_high_ovf(t3h), .i_cmp_one_rise_flag(c1r),
        .i_cmp_one_fall_flag(c1f), .i_cmp_zero_rise_flag(c0r), .i_cmp_zero_fall_flag(c0f),
        .i_counter_array_req(pca), .i_conv_done_flag(conv), .i_window_cmp_flag(win),
        .i_usb_ctrl_req(usb), .i_smbus_ctrl_req(smb), .i_uart_one_req(u1),
        .i_bus_supply_req(vb), .o_ext_irq_zero(ez), .o_ext_irq_one(eo), .o_irq_valid(vld),
        .o_irq_high(hi), .o_irq_src(src));

    initial forever #50 clk = ~clk;

    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; byte address is four times the register index
    task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {22'h0, idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = rdat[7:0];
        check(ack, 1'b1);
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic t_regs;
        logic [7:0] idx[6] = '{iepx_pkg::IDX_PRIO_BASE, iepx_pkg::IDX_EN_EXT_ONE,
            iepx_pkg::IDX_EN_EXT_TWO, iepx_pkg::IDX_EXT_CFG, iepx_pkg::IDX_PRIO_EXT1,
            iepx_pkg::IDX_PRIO_EXT2};
        logic [7:0] rv[6] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        logic [7:0] mk[6] = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h03};
        for (int i = 0; i < 6; i++) begin
            wb(idx[i], 0, 8'h00);
            check(rd, rv[i]);
            wb(idx[i], 1, 8'hff);
            wb(idx[i], 0, 8'h00);
            check(rd, mk[i]);
            wb(idx[i], 1, 8'h00);
            wb(idx[i], 0, 8'h00);
            check(rd, (i == 0) ? 8'h80 : 8'h00);
        end
        wb(8'hff, 0, 8'h00);
        check(rd, 8'h00);
    endtask

    // all sources request, only one is let through at a time
    task automatic t_mask;
        wb(iepx_pkg::IDX_GLOBAL_EN, 1, 8'h01);
        for (int a = 0; a < 2; a++) begin
            for (int i = 0; i < 17; i++) begin
                logic [16:0] m;
                m = 17'h1 << i;
                @(posedge clk);
                ben <= m[6:0];
                req <= '1;
                alt <= a[0];
                wb(iepx_pkg::IDX_EN_EXT_ONE, 1, m[14:7]);
                wb(iepx_pkg::IDX_EN_EXT_TWO, 1, {6'h0, m[16], m[15]});
                settle();
                check(vld, 1'b1);
                check(src, i[4:0]);
            end
        end
    endtask

    task automatic t_prio;
        @(posedge clk);
        ben <= '1;
        wb(iepx_pkg::IDX_EN_EXT_ONE, 1, 8'hff);
        wb(iepx_pkg::IDX_EN_EXT_TWO, 1, 8'h03);
        settle();
        check({hi, src}, 6'h00);
        wb(iepx_pkg::IDX_PRIO_EXT2, 1, 8'h02);
        settle();
        check({hi, src}, 6'h30);
        wb(iepx_pkg::IDX_PRIO_EXT1, 1, 8'h80);
        settle();
        check({hi, src}, 6'h2e);
        wb(iepx_pkg::IDX_PRIO_BASE, 1, 8'h40);
        settle();
        check({hi, src}, 6'h26);
        wb(iepx_pkg::IDX_STATUS, 0, 8'h00);
        check(rd, 8'hc6);
        wb(iepx_pkg::IDX_GLOBAL_EN, 0, 8'h00);
        check(rd, 8'h01);
        wb(iepx_pkg::IDX_GLOBAL_EN, 1, 8'h00);
        settle();
        check(vld, 1'b0);
    endtask

    // one input on pin p active high, the other on pin 7-p active low
    task automatic t_pins;
        for (int p = 0; p < 8; p++) begin
            wb(iepx_pkg::IDX_EXT_CFG, 1, {1'b1, p[2:0], 1'b0, 3'(7 - p)});
            @(posedge clk);
            port <= 8'h01 << p;
            repeat (8) @(posedge clk);
            #1 check({eo, ez}, 2'b11);
            @(posedge clk);
            port <= ~(8'h01 << p);
            repeat (8) @(posedge clk);
            #1 check({eo, ez}, 2'b00);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        #1 check(src, iepx_pkg::SRC_NONE);
        t_regs();
        t_mask();
        t_prio();
        t_pins();
        print_verdict();
    end
endmodule
